//--- design/ppp_dev_end.sv
// Device end: command decode, page buffers, memories, read back
`timescale 1ns/1ps
`default_nettype none
module ppp_dev_end #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h01, // Arbitrary value
  parameter logic [7:0] CALIB     = 8'h80  // Arbitrary value
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_B_IN,
  ppp_pins_if.dev         PINS,
  output var  logic [7:0] CMD_OUT,
  output var  logic [7:0] LOCK_OUT
);
  import ppp_pkg::*;

  typedef struct packed {
    logic [7:0]                 cmd;
    logic [7:0]                 alo;
    logic [7:0]                 ahi;
    logic [7:0]                 dlo;
    logic [7:0]                 dhi;
    logic [FL_PW-1:0][15:0]     fbuf;
    logic [FL_PW-1:0]           fmask;
    logic [EE_PW-1:0][7:0]      ebuf;
    logic [EE_PW-1:0]           emask;
    logic [FL_WORDS-1:0][15:0]  flash;
    logic [EE_BYTES-1:0][7:0]   ee;
    logic [7:0]                 fuse_lo;
    logic [7:0]                 fuse_hi;
    logic [7:0]                 fuse_ext;
    logic [7:0]                 lock;
    logic [BUSY_W-1:0]          busy_cnt;
    logic                       rdy;
    logic [7:0]                 dout;
    logic                       doe;
  } ppp_dev_st_t;

  ppp_dev_st_t s;
  ppp_dev_st_t n;

  logic              load_rise;
  logic              latch_rise;
  logic              commit_fall;
  logic [15:0]       addr;
  logic [FL_AW-1:0]  faddr;
  logic [EE_AW-1:0]  eaddr;
  logic [FL_AW-FL_WB-1:0] fpage;
  logic [EE_AW-EE_WB-1:0] epage;
  logic [FL_WB-1:0]  fword;
  logic [EE_WB-1:0]  eword;
  logic [1:0]        sel;
  logic [1:0]        xa;
  logic              bs;
  logic [7:0]        rd_val;
  logic              mode3;

  ppp_edge u_load (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .sig_in   (PINS.load_strobe),
    .rise_out (load_rise),
    .fall_out ()
  );
  ppp_edge u_latch (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .sig_in   (PINS.page_latch_strobe),
    .rise_out (latch_rise),
    .fall_out ()
  );
  ppp_edge u_commit (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .sig_in   (PINS.commit_strobe_n),
    .rise_out (),
    .fall_out (commit_fall)
  );

  assign addr  = {s.ahi, s.alo};
  assign faddr = addr[FL_AW-1:0];
  assign eaddr = addr[EE_AW-1:0];
  assign fpage = faddr[FL_AW-1:FL_WB];
  assign epage = eaddr[EE_AW-1:EE_WB];
  assign fword = s.alo[FL_WB-1:0];
  assign eword = s.alo[EE_WB-1:0];
  assign bs    = PINS.byte_select;
  assign sel   = {PINS.second_byte_select, PINS.byte_select};
  assign xa    = {PINS.action_select_hi, PINS.action_select_lo};
  assign mode3 = (s.lock[1:0] == 2'b00);

  // Read data selection
  always_comb begin
    rd_val = IDLE_BUS;
    case (s.cmd)
      CMD_RD_FLASH: begin
        rd_val = bs ? s.flash[faddr][15:8] : s.flash[faddr][7:0];
      end
      CMD_RD_EE: begin
        if (!bs) begin
          rd_val = s.ee[eaddr];
        end
      end
      CMD_RD_FUSE: begin
        case (sel)
          2'b00:   rd_val = s.fuse_lo;
          2'b11:   rd_val = s.fuse_hi;
          2'b10:   rd_val = s.fuse_ext;
          default: rd_val = s.lock;
        endcase
      end
      CMD_RD_SIG: begin
        if (!bs) begin
          case (s.alo)
            8'h00:   rd_val = SIG_BYTE0;
            8'h01:   rd_val = SIG_BYTE1;
            SIG_LAST: rd_val = SIG_BYTE2;
            default: rd_val = IDLE_BUS;
          endcase
        end else if (s.alo == 8'h00) begin
          rd_val = CALIB;
        end
      end
      default: rd_val = IDLE_BUS;
    endcase
  end

  always_comb begin
    n = s;
    if (s.busy_cnt != '0) begin
      n.busy_cnt = s.busy_cnt - 1'b1;
    end
    // Loads: command, address and data stay held
    if (load_rise && s.rdy) begin
      case (xa)
        XA_CMD: begin
          if (!bs) begin
            n.cmd = PINS.data_bus;
            if (PINS.data_bus == CMD_NOP) begin
              n.fmask = '0;
              n.emask = '0;
            end
          end
        end
        XA_ADDR: begin
          if (bs) begin
            n.ahi = PINS.data_bus;
          end else begin
            n.alo = PINS.data_bus;
          end
        end
        XA_DATA: begin
          if (bs) begin
            n.dhi = PINS.data_bus;
          end else begin
            n.dlo = PINS.data_bus;
          end
        end
        default: ;
      endcase
    end
    // Page latch into buffers
    if (latch_rise && s.rdy && bs) begin
      if (s.cmd == CMD_WR_FLASH) begin
        n.fbuf[fword]  = {s.dhi, s.dlo};
        n.fmask[fword] = 1'b1;
      end else if (s.cmd == CMD_WR_EE) begin
        n.ebuf[eword]  = s.dlo;
        n.emask[eword] = 1'b1;
      end
    end
    // Commit: program and start busy time
    if (commit_fall && s.rdy) begin
      case (s.cmd)
        CMD_WR_FLASH: begin
          for (int i = 0; i < FL_PW; i++) begin
            if (s.fmask[i]) begin
              n.flash[{fpage, FL_WB'(i)}] = s.fbuf[i];
            end
          end
          n.fmask    = '0;
          n.busy_cnt = PROG_CYC;
        end
        CMD_WR_EE: begin
          if (!bs) begin
            for (int i = 0; i < EE_PW; i++) begin
              if (s.emask[i]) begin
                n.ee[{epage, EE_WB'(i)}] = s.ebuf[i];
              end
            end
            n.emask    = '0;
            n.busy_cnt = PROG_CYC;
          end
        end
        CMD_WR_FUSE: begin
          case (sel)
            2'b00:   n.fuse_lo  = s.dlo;
            2'b01:   n.fuse_hi  = s.dlo;
            2'b10:   n.fuse_ext = s.dlo;
            default: ;
          endcase
          n.busy_cnt = PROG_CYC;
        end
        CMD_WR_LOCK: begin
          // Only programs zeros; boot bits frozen in mode 3
          if (mode3) begin
            n.lock = s.lock & (s.dlo | BOOT_LOCK_MSK);
          end else begin
            n.lock = s.lock & s.dlo;
          end
          n.busy_cnt = PROG_CYC;
        end
        CMD_ERASE: begin
          n.flash    = '1;
          n.ee       = '1;
          n.lock     = LOCK_RST;
          n.fmask    = '0;
          n.emask    = '0;
          n.busy_cnt = ERASE_CYC;
        end
        default: ;
      endcase
    end
    n.rdy  = (n.busy_cnt == '0);
    n.doe  = ~PINS.oe_n;
    n.dout = rd_val;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s          <= '0;
      s.flash    <= '1;
      s.ee       <= '1;
      s.fuse_lo  <= FUSE_LO_RST;
      s.fuse_hi  <= FUSE_HI_RST;
      s.fuse_ext <= FUSE_EXT_RST;
      s.lock     <= LOCK_RST;
      s.rdy      <= 1'b1;
      s.dout     <= IDLE_BUS;
    end else begin
      s <= n;
    end
  end

  assign PINS.dev_data             = s.dout;
  assign PINS.dev_data_oe          = s.doe;
  assign PINS.completion_indicator = s.rdy;
  assign CMD_OUT                   = s.cmd;
  assign LOCK_OUT                  = s.lock;
endmodule
`default_nettype wire

//--- design/ppp_edge.sv
// Strobe synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module ppp_edge (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic sig_in,
  output var  logic rise_out,
  output var  logic fall_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } ppp_edge_st_t;

  ppp_edge_st_t s;
  ppp_edge_st_t n;

  always_comb begin
    n      = s;
    n.s1   = sig_in;
    n.s2   = s.s1;
    n.s3   = s.s2;
    n.rise = s.s2 & ~s.s3;
    n.fall = ~s.s2 & s.s3;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rise_out = s.rise;
  assign fall_out = s.fall;
endmodule
`default_nettype wire

//--- design/ppp_prog_end.sv
// Programmer end: AXI4-Lite order register drives the pin sequence
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_end (
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  ppp_pins_if.prog         PINS,
  input  wire logic [3:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output var  logic        S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output var  logic        S_AXI_WREADY_OUT,
  output var  logic [1:0]  S_AXI_BRESP_OUT,
  output var  logic        S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [3:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output var  logic        S_AXI_ARREADY_OUT,
  output var  logic [31:0] S_AXI_RDATA_OUT,
  output var  logic [1:0]  S_AXI_RRESP_OUT,
  output var  logic        S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN
);
  import ppp_pkg::*;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [3:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    ppp_seq_t          seq;
    logic [CNT_W-1:0]  cnt;
    ppp_op_t           op;
    logic [15:0]       order;
    logic [7:0]        rd_data;
    logic              load;
    logic              latch;
    logic              commit_n;
    logic              oe_n;
    logic              xa_hi;
    logic              xa_lo;
    logic              bs;
    logic              bsec;
    logic [7:0]        pdata;
    logic              poe;
  } ppp_prog_st_t;

  ppp_prog_st_t s;
  ppp_prog_st_t n;

  always_comb begin
    n = s;
    if (S_AXI_AWVALID_IN && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA_IN;
      n.wstrb = S_AXI_WSTRB_IN;
    end
    if (s.bvalid && S_AXI_BREADY_IN) begin
      n.bvalid = 1'b0;
    end
    // Write takes effect once address and data are both held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_SLVERR;
      if (s.awaddr == REG_ORDER && s.seq == PPP_IDLE &&
          s.wstrb[1:0] == 2'h3) begin
        n.bresp = RESP_OKAY;
        n.order = s.wdata[15:0];
        n.op    = ppp_op_t'(s.wdata[ORD_OP_LSB +: 2]);
        n.xa_hi = s.wdata[ORD_XA_LSB + 1];
        n.xa_lo = s.wdata[ORD_XA_LSB];
        n.bs    = s.wdata[ORD_BS_BIT];
        n.bsec  = s.wdata[ORD_BSEC_BIT];
        n.pdata = s.wdata[ORD_BYTE_LSB +: 8];
        n.poe   = (s.wdata[ORD_OP_LSB +: 2] != PPP_OP_READ);
        n.cnt   = PULSE_CYC;
        n.seq   = PPP_SETUP;
      end
    end
    if (s.rvalid && S_AXI_RREADY_IN) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      case (S_AXI_ARADDR_IN)
        REG_ORDER: n.rdata[15:0] = s.order;
        REG_STATUS: begin
          n.rdata[ST_BUSY_BIT]          = (s.seq != PPP_IDLE);
          n.rdata[ST_RDY_BIT]           = PINS.completion_indicator;
          n.rdata[ST_DATA_LSB +: 8]     = s.rd_data;
        end
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    // Pin sequencer: setup, wait for ready (reads do not wait), strobe, hold
    case (s.seq)
      PPP_IDLE: ;
      PPP_SETUP: begin
        n.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          n.seq = PPP_WAIT;
        end
      end
      PPP_WAIT: begin
        if (s.op == PPP_OP_READ || PINS.completion_indicator) begin
          n.seq      = PPP_PULSE;
          n.cnt      = PULSE_CYC;
          n.load     = (s.op == PPP_OP_LOAD);
          n.latch    = (s.op == PPP_OP_LATCH);
          n.commit_n = (s.op != PPP_OP_COMMIT);
          n.oe_n     = (s.op != PPP_OP_READ);
        end
      end
      PPP_PULSE: begin
        n.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          if (s.op == PPP_OP_READ) begin
            n.rd_data = PINS.data_bus;
          end
          n.load     = 1'b0;
          n.latch    = 1'b0;
          n.commit_n = 1'b1;
          n.oe_n     = 1'b1;
          n.cnt      = PULSE_CYC;
          n.seq      = PPP_HOLD;
        end
      end
      PPP_HOLD: begin
        n.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          n.poe = 1'b0;
          n.seq = PPP_IDLE;
        end
      end
      default: n.seq = PPP_IDLE;
    endcase
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready  = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s          <= '0;
      s.seq      <= PPP_IDLE;
      s.commit_n <= 1'b1;
      s.oe_n     <= 1'b1;
      s.xa_hi    <= 1'b1;
      s.xa_lo    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign S_AXI_AWREADY_OUT       = s.awready;
  assign S_AXI_WREADY_OUT        = s.wready;
  assign S_AXI_BRESP_OUT         = s.bresp;
  assign S_AXI_BVALID_OUT        = s.bvalid;
  assign S_AXI_ARREADY_OUT       = s.arready;
  assign S_AXI_RDATA_OUT         = s.rdata;
  assign S_AXI_RRESP_OUT         = s.rresp;
  assign S_AXI_RVALID_OUT        = s.rvalid;
  assign PINS.load_strobe        = s.load;
  assign PINS.page_latch_strobe  = s.latch;
  assign PINS.commit_strobe_n    = s.commit_n;
  assign PINS.oe_n               = s.oe_n;
  assign PINS.action_select_hi   = s.xa_hi;
  assign PINS.action_select_lo   = s.xa_lo;
  assign PINS.byte_select        = s.bs;
  assign PINS.second_byte_select = s.bsec;
  assign PINS.prog_data          = s.pdata;
  assign PINS.prog_data_oe       = s.poe;
endmodule
`default_nettype wire

//--- inc/ppp_pins_if.sv
// Pin bundle between the programmer and the device
`timescale 1ns/1ps
`default_nettype none
interface ppp_pins_if;
  logic       load_strobe;
  logic       page_latch_strobe;
  logic       commit_strobe_n;
  logic       oe_n;
  logic       action_select_hi;
  logic       action_select_lo;
  logic       byte_select;
  logic       second_byte_select;
  logic [7:0] prog_data;
  logic       prog_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic [7:0] data_bus;
  logic       completion_indicator;

  // Bus level, pulled high when nobody drives
  assign data_bus = dev_data_oe ? dev_data :
                    prog_data_oe ? prog_data : 8'hff;

  modport dev (
    input  load_strobe, page_latch_strobe, commit_strobe_n, oe_n,
    input  action_select_hi, action_select_lo, byte_select,
    input  second_byte_select, data_bus,
    output dev_data, dev_data_oe, completion_indicator
  );
  modport prog (
    output load_strobe, page_latch_strobe, commit_strobe_n, oe_n,
    output action_select_hi, action_select_lo, byte_select,
    output second_byte_select, prog_data, prog_data_oe,
    input  data_bus, completion_indicator
  );
endinterface
`default_nettype wire

//--- inc/ppp_pkg.sv
// Constants and types of the parallel programming port
// Summary of operation
// - Action 10, byte select 0: load command
// - Action 00: load address low or high
// - Action 01: load data low or high
// - Page latch with byte select high buffers word
// - Programmer fills page, loads high address, commits
// - Low address bits word, upper bits page
// - Commit starts page write; wait for ready
// - No-operation command clears write state
// - EEPROM page written by commit, byte select 0
// - Flash read: byte select picks word byte
// - EEPROM read with byte select 0
// - Fuse write from data low, commit, wait
// - Byte selects pick low, high, extended fuse
// - Lock write programs zeros; mode 3 guards boot
// - Lock bits cleared only by chip erase
// - Fuse and lock read by select pair
// - Signature bytes at low address 0 to 2
// - Calibration byte at address 0, select 1
// - Device drives bus only while output enable low
// - Command and address held between operations
// - Chip erase command plus commit, busy shown
package ppp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS      = 250;
  localparam int PROG_TIME_NS  = 2000;
  localparam int ERASE_TIME_NS = 4000;
  localparam int BUSY_W        = 10;
  localparam int CNT_W         = 6;
  localparam logic [BUSY_W-1:0] PROG_CYC =
    BUSY_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [BUSY_W-1:0] ERASE_CYC =
    BUSY_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_CYC =
    CNT_W'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int FL_AW    = 6;
  localparam int FL_WB    = 3;
  localparam int FL_PW    = 1 << FL_WB;
  localparam int FL_WORDS = 1 << FL_AW;
  localparam int EE_AW    = 5;
  localparam int EE_WB    = 2;
  localparam int EE_PW    = 1 << EE_WB;
  localparam int EE_BYTES = 1 << EE_AW;

  localparam logic [1:0] XA_ADDR = 2'h0;
  localparam logic [1:0] XA_DATA = 2'h1;
  localparam logic [1:0] XA_CMD  = 2'h2;

  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  localparam logic [7:0] FUSE_LO_RST   = 8'hff;
  localparam logic [7:0] FUSE_HI_RST   = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST  = 8'hff;
  localparam logic [7:0] LOCK_RST      = 8'hff;
  localparam logic [7:0] BOOT_LOCK_MSK = 8'h3c;
  localparam logic [7:0] SIG_LAST      = 8'h02;
  localparam logic [7:0] IDLE_BUS      = 8'hff;

  localparam logic [3:0] REG_ORDER  = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int ORD_BYTE_LSB = 0;
  localparam int ORD_XA_LSB   = 8;
  localparam int ORD_BS_BIT   = 10;
  localparam int ORD_BSEC_BIT = 11;
  localparam int ORD_OP_LSB   = 12;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_RDY_BIT   = 1;
  localparam int ST_DATA_LSB  = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPP_OP_LOAD   = 2'b00,
    PPP_OP_LATCH  = 2'b01,
    PPP_OP_COMMIT = 2'b10,
    PPP_OP_READ   = 2'b11
  } ppp_op_t;

  typedef enum logic [2:0] {
    PPP_IDLE  = 3'b000,
    PPP_SETUP = 3'b001,
    PPP_WAIT  = 3'b010,
    PPP_PULSE = 3'b011,
    PPP_HOLD  = 3'b100
  } ppp_seq_t;
endpackage

//--- tb/ppp_sva.sv
// Checker on the pins between programmer end and device end
`timescale 1ns/1ps
`default_nettype none
module ppp_sva
  import ppp_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       load_strobe,
  input wire logic       commit_strobe_n,
  input wire logic       oe_n,
  input wire logic       action_select_hi,
  input wire logic       action_select_lo,
  input wire logic       byte_select,
  input wire logic [7:0] data_bus,
  input wire logic       dev_data_oe,
  input wire logic       completion_indicator,
  input wire logic [7:0] CMD_OUT,
  input wire logic [7:0] LOCK_OUT
);
  logic [9:0] busy_cnt;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Busy length counter
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) busy_cnt <= 10'h0;
    else busy_cnt <= completion_indicator ? 10'h0 : busy_cnt + 10'h1;
  end
  sequence s_cmd_load;
    $rose(load_strobe) && !byte_select && completion_indicator &&
      {action_select_hi, action_select_lo} == XA_CMD;
  endsequence
  sequence s_commit;
    $fell(commit_strobe_n) && completion_indicator &&
      (CMD_OUT == CMD_WR_FLASH || CMD_OUT == CMD_ERASE);
  endsequence
  a_cmd_load: assert property (
    s_cmd_load |-> ##[2:6] CMD_OUT == data_bus)
    else $error("command not loaded");
  a_commit_busy: assert property (
    s_commit |-> ##[2:8] !completion_indicator)
    else $error("commit without busy");
  a_busy_time: assert property ($rose(completion_indicator) |->
    busy_cnt == PROG_CYC || busy_cnt == ERASE_CYC)
    else $error("busy length wrong");
  a_busy_ignore: assert property (!completion_indicator &&
    !$past(completion_indicator) |-> $stable(CMD_OUT))
    else $error("command changed while busy");
  a_cmd_held: assert property ($changed(CMD_OUT) |-> load_strobe)
    else $error("command changed without load");
  a_lock_clear: assert property (CMD_OUT != CMD_ERASE &&
    $past(CMD_OUT) != CMD_ERASE |-> (LOCK_OUT & ~$past(LOCK_OUT)) == 8'h00)
    else $error("lock bit cleared");
  a_boot_guard: assert property (($past(LOCK_OUT) & 8'h03) == 8'h00 &&
    CMD_OUT != CMD_ERASE |->
    (LOCK_OUT & BOOT_LOCK_MSK) == ($past(LOCK_OUT) & BOOT_LOCK_MSK))
    else $error("boot lock changed in mode 3");
  a_bus_drive: assert property (dev_data_oe |-> !$past(oe_n))
    else $error("bus driven without enable");
  a_bus_turn: assert property ($fell(oe_n) |=> dev_data_oe)
    else $error("bus not driven on enable");
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Bench joining programmer end and device end over the pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppp_pkg::*;
  // Arbitrary signature and calibration values
  localparam logic [7:0] SIGS [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic        clk;
  logic        rst_b;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  cmd;
  logic [7:0]  lock;
  logic [31:0] st;
  logic [1:0]  rsp;
  int          bad_count;
  int          cmp_count;
  ppp_pins_if pins ();
  ppp_dev_end #(.SIG_BYTE0(SIGS[0]), .SIG_BYTE1(SIGS[1]),
    .SIG_BYTE2(SIGS[2]), .CALIB(SIGS[3])) ppp_dev_end_i (.CLK_IN(clk),
    .RST_B_IN(rst_b), .PINS(pins.dev), .CMD_OUT(cmd), .LOCK_OUT(lock));
  ppp_prog_end ppp_prog_end_i (.CLK_IN(clk), .RST_B_IN(rst_b),
    .PINS(pins.prog), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready));
  ppp_sva ppp_sva_i (.CLK_IN(clk), .RST_B_IN(rst_b),
    .load_strobe(pins.load_strobe), .commit_strobe_n(pins.commit_strobe_n),
    .oe_n(pins.oe_n), .action_select_hi(pins.action_select_hi),
    .action_select_lo(pins.action_select_lo),
    .byte_select(pins.byte_select), .data_bus(pins.data_bus),
    .dev_data_oe(pins.dev_data_oe),
    .completion_indicator(pins.completion_indicator),
    .CMD_OUT(cmd), .LOCK_OUT(lock));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    st = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // One pin order, then wait for the sequencer
  task automatic ord(input logic [1:0] op, xa, input logic bs, b2,
                     input logic [7:0] b);
    wr(REG_ORDER, {18'h0, op, b2, bs, xa, b});
    chk("order resp", rsp, RESP_OKAY);
    do rd(REG_STATUS); while (st[ST_BUSY_BIT]);
  endtask
  task automatic ld(input logic [1:0] xa, input logic bs, input logic [7:0] b);
    ord(2'h0, xa, bs, 1'b0, b);
  endtask
  task automatic lt();
    ord(2'h1, 2'h3, 1'b1, 1'b0, 8'h0);
  endtask
  task automatic cm(input logic bs, b2);
    ord(2'h2, 2'h3, bs, b2, 8'h0);
    chk("busy", st[ST_RDY_BIT], 1'b0);
  endtask
  task automatic rb(input logic bs, b2, input logic [7:0] e);
    ord(2'h3, 2'h3, bs, b2, 8'h0);
    chk("read byte", st[15:8], e);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    wstrb = 4'hf;
    {araddr, arvalid, rready, bad_count, cmp_count} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("cmd reset", cmd, CMD_NOP);
    chk("lock reset", lock, LOCK_RST);
    wr(4'h8, 32'h0);
    chk("unmapped wr", rsp, RESP_SLVERR);
    rd(4'hc);
    chk("unmapped rd", {rsp, st[29:0]}, {RESP_SLVERR, 30'h0});
    wstrb <= 4'hc;
    wr(REG_ORDER, 32'h0);
    chk("strobe wr", rsp, RESP_SLVERR);
    wstrb <= 4'hf;
    wr(REG_ORDER, 32'h3300);
    wr(REG_ORDER, 32'h3300);
    chk("busy order", rsp, RESP_SLVERR);
    rd(REG_ORDER);
    chk("order rd", st, 32'h3300);
    do rd(REG_STATUS); while (st[ST_BUSY_BIT]);
    ld(2'h2, 1'b0, CMD_RD_SIG);
    chk("cmd", cmd, CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      ld(2'h0, 1'b0, 8'(i));
      rb(1'b0, 1'b0, SIGS[i]);
    end
    ld(2'h0, 1'b0, 8'h0);
    rb(1'b1, 1'b0, SIGS[3]);
    ld(2'h2, 1'b0, CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      ld(2'h1, 1'b0, 8'h12 + 8'(i));
      cm(i == 1, i == 2);
    end
    ld(2'h2, 1'b0, CMD_RD_FUSE);
    rb(1'b0, 1'b0, 8'h12);
    rb(1'b1, 1'b1, 8'h13);
    rb(1'b0, 1'b1, 8'h14);
    ld(2'h2, 1'b0, CMD_WR_FLASH);
    for (int w = 0; w < 2; w++) begin
      ld(2'h0, 1'b0, 8'h8 + 8'(w));
      ld(2'h1, 1'b0, 8'ha0 + 8'(w));
      ld(2'h1, 1'b1, 8'hb0 + 8'(w));
      lt();
    end
    ld(2'h0, 1'b1, 8'h0);
    cm(1'b0, 1'b0);
    ld(2'h0, 1'b0, 8'ha);
    lt();
    ld(2'h2, 1'b0, CMD_NOP);
    chk("nop", cmd, CMD_NOP);
    ld(2'h2, 1'b0, CMD_WR_FLASH);
    cm(1'b0, 1'b0);
    ld(2'h2, 1'b0, CMD_RD_FLASH);
    for (int a = 7; a < 11; a++) begin
      ld(2'h0, 1'b0, 8'(a));
      rb(1'b0, 1'b0, (a == 8 || a == 9) ? 8'h98 + 8'(a) : 8'hff);
      rb(1'b1, 1'b0, (a == 8 || a == 9) ? 8'ha8 + 8'(a) : 8'hff);
    end
    ld(2'h2, 1'b0, CMD_WR_EE);
    ld(2'h0, 1'b1, 8'h0);
    ld(2'h0, 1'b0, 8'h5);
    ld(2'h1, 1'b0, 8'h3c);
    lt();
    cm(1'b0, 1'b0);
    ld(2'h2, 1'b0, CMD_RD_EE);
    rb(1'b0, 1'b0, 8'h3c);
    ld(2'h0, 1'b0, 8'h6);
    rb(1'b0, 1'b0, 8'hff);
    ld(2'h2, 1'b0, CMD_WR_LOCK);
    ld(2'h1, 1'b0, 8'hfc);
    cm(1'b0, 1'b0);
    ld(2'h1, 1'b0, 8'hc3);
    cm(1'b0, 1'b0);
    ld(2'h2, 1'b0, CMD_RD_FUSE);
    chk("lock", lock, 8'hfc);
    rb(1'b1, 1'b0, 8'hfc);
    ld(2'h2, 1'b0, CMD_ERASE);
    cm(1'b0, 1'b0);
    ld(2'h2, 1'b0, CMD_RD_FUSE);
    rb(1'b1, 1'b0, LOCK_RST);
    ld(2'h2, 1'b0, CMD_RD_FLASH);
    ld(2'h0, 1'b0, 8'h8);
    rb(1'b0, 1'b0, 8'hff);
    results();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
